//--- hdl/hsptr_pkg.sv
package hsptr_pkg;
    // register indices on the 8-bit cpu data bus
    localparam logic [3:0] ADDR_CNT_LO   = 4'h0; // counter_low_byte
    localparam logic [3:0] ADDR_HIGH     = 4'h1; // shared_high_bits_staging
    localparam logic [3:0] ADDR_CMP_A    = 4'h2; // compare_a_value
    localparam logic [3:0] ADDR_CMP_B    = 4'h3; // compare_b_value
    localparam logic [3:0] ADDR_PERIOD   = 4'h4; // period_top_value
    localparam logic [3:0] ADDR_CMP_D    = 4'h5; // compare_d_value
    localparam logic [3:0] ADDR_MASK     = 4'h6; // timer_interrupt_mask
    localparam logic [3:0] ADDR_FLAGS    = 4'h7; // timer_interrupt_flags
    localparam logic [3:0] ADDR_DEAD     = 4'h8; // dead_time_setting
    localparam logic [3:0] ADDR_OVERRIDE = 4'h9; // pin_override_en_bit group

    // event index: 0 = a, 1 = b, 2 = d, 3 = overflow
    localparam int          NUM_CH   = 3;
    localparam int          NUM_EVT  = 4;
    localparam int          EVT_OVF  = 3;
    // bit positions in mask and flag bytes, by event index
    localparam int          FLG_POS [NUM_EVT] = '{6, 5, 7, 2};

    // staging byte fields
    localparam int          HS_EXTRA_MSB = 2; // enhanced_extra_msb
    localparam logic [7:0]  HS_RSVD_MASK = 8'hf8;

    // dead time nibble positions
    localparam int          DT_TRUE_LSB  = 4;
    localparam int          DT_COMPL_LSB = 0;

    // reset values and period floor
    localparam logic [9:0]  CNT_RST      = 10'h000;
    localparam logic [10:0] CMP_RST      = 11'h000;
    localparam logic [9:0]  PERIOD_RST   = 10'h3ff;
    localparam logic [9:0]  PERIOD_MIN   = 10'h003;
    localparam logic [7:0]  DEAD_RST     = 8'h00;

    // counter write landing delay, cpu clock at 10 ns
    localparam int          CPU_CLK_PERIOD_NS   = 10;
    localparam int          WR_DLY_SYNC_HALVES  = 3; // one and a half cpu clocks
    localparam logic [1:0]  WR_DLY_SYNC_CYC     = 2'((WR_DLY_SYNC_HALVES + 1) / 2);
    localparam logic [1:0]  WR_DLY_ASYNC_CYC    = 2'h1;
endpackage

//--- hdl/hsptr_deadtime.sv
`timescale 1ns/10ps
// complementary output pair with independent dead times
module hsptr_deadtime (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       wave_in,
    input  wire logic [3:0] dt_true,
    input  wire logic [3:0] dt_compl,
    output logic            true_out,
    output logic            compl_out
);
    logic       wave_d_r; // last seen waveform
    logic [3:0] dly_r;    // remaining dead time in prescaled ticks

    // both outputs off during dead time, then follow the waveform
    always_ff @(posedge clk) begin
        if (rst) begin
            wave_d_r  <= 1'b0;
            dly_r     <= 4'h0;
            true_out  <= 1'b0;
            compl_out <= 1'b0;
        end else begin
            wave_d_r <= wave_in;
            if (wave_in != wave_d_r) begin
                // edge: drop both, load the delay for the rising side
                true_out  <= 1'b0;
                compl_out <= 1'b0;
                dly_r     <= wave_in ? dt_true : dt_compl;
            end else if (dly_r != 4'h0) begin
                // count down in prescaled clocks
                if (tick) begin
                    dly_r <= dly_r - 4'h1;
                end
            end else begin
                true_out  <= wave_in;
                compl_out <= ~wave_in;
            end
        end
    end
endmodule

//--- hdl/hsptr_top.sv
`timescale 1ns/10ps
// Functional notes
// - six-channel mode: override bit picks waveform or port
// - ten-bit up/down counter, software readable and writable
// - counter write lands after sync delay
// - counter write restarts counting upward
// - one shared staging byte holds bits nine, eight
// - staging bit two is extra enhanced msb
// - staging bits seven to three read zero
// - match only when counter counts onto value
// - match sets channel flag after sync delay
// - normal/fast: period register clears counter on match
// - period writes below three store three
// - compare irq needs enable, global bit, flag
// - overflow irq needs enable, global bit, flag
// - flags clear on vector or written one
// - normal/fast: overflow flag when top wraps
// - dual slope: overflow flag when zero loads
// - dead time nibbles: upper true, lower complementary
// - low bytes alone give plain 8-bit timer
module hsptr_top (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [3:0]               cpu_addr,
    input  wire logic                     cpu_wr,
    input  wire logic                     cpu_rd,
    input  wire logic [7:0]               cpu_wdata,
    output logic      [7:0]               cpu_rdata,
    input  wire logic                     cpu_status_word_ibit,
    input  wire logic [hsptr_pkg::NUM_EVT-1:0] vec_done,
    input  wire logic                     timer_tick,
    input  wire logic                     pwm_enable,
    input  wire logic [1:0]               wgm_mode,
    input  wire logic                     enhanced_mode,
    input  wire logic                     async_clocking,
    input  wire logic [5:0]               port_value,
    output logic      [5:0]               pin_out,
    output logic      [hsptr_pkg::NUM_EVT-1:0] irq_req
);
    import hsptr_pkg::*;

    logic [9:0]         cnt_r;       // count_value
    logic               dir_down_r;  // counting direction
    logic               moved_r;     // counter changed by counting last edge
    logic [2:0]         hs_r;        // high_bits_staging
    logic [10:0]        cmp_r [NUM_CH]; // cmp_a/b/d_value
    logic [9:0]         period_r;    // period_value
    logic [7:0]         dead_r;      // dead_time_true_out / compl_out
    logic [5:0]         ovr_r;       // pin_override_en_bit
    logic [NUM_EVT-1:0] mask_r;      // irq enables
    logic [NUM_EVT-1:0] flag_r;      // event flags
    logic [NUM_EVT-1:0] clr_pend_r;  // written-one clears, one cycle late
    logic [NUM_EVT-1:0] set_evt;     // hardware set per event
    logic [NUM_CH-1:0]  match;       // counted-onto compare match
    logic [NUM_CH-1:0]  match_d_r;   // match after sync stage
    logic [NUM_CH-1:0]  wave_r;      // waveform per channel
    logic [5:0]         pair_w;      // dead time pair outputs
    logic [1:0]         pend_cnt_r;  // counter write countdown
    logic [9:0]         pend_val_r;  // counter write value
    logic               land;        // counter write lands now
    logic               wrap_now;    // overflow event this edge
    logic               phase_mode;  // dual slope
    logic               six_mode;    // six_channel_mode
    logic [9:0]         period_wr;   // assembled period write
    logic [7:0]         mask_byte;   // mask readback
    logic [7:0]         flag_byte;   // flag readback

    // mode decode
    assign phase_mode = pwm_enable & wgm_mode[0];
    assign six_mode   = pwm_enable & wgm_mode[1];
    assign land       = (pend_cnt_r == 2'h1);

    // overflow: wrap at top, or zero clocked in when counting down
    always_comb begin
        wrap_now = 1'b0;
        if (timer_tick && !land) begin
            if (!phase_mode) begin
                wrap_now = (cnt_r >= period_r);
            end else begin
                wrap_now = dir_down_r && (cnt_r <= 10'h001);
            end
        end
    end

    // counter write staging: lands after the cpu sync delay
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_cnt_r <= 2'h0;
            pend_val_r <= CNT_RST;
        end else if (cpu_wr && cpu_addr == ADDR_CNT_LO) begin
            // high bits come from staging, written first
            pend_val_r <= {hs_r[1:0], cpu_wdata};
            pend_cnt_r <= async_clocking ? WR_DLY_ASYNC_CYC : WR_DLY_SYNC_CYC;
        end else if (pend_cnt_r != 2'h0) begin
            pend_cnt_r <= pend_cnt_r - 2'h1;
        end
    end

    // up/down counter
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r      <= CNT_RST;
            dir_down_r <= 1'b0;
            moved_r    <= 1'b0;
        end else begin
            moved_r <= 1'b0;
            if (land) begin
                // software value, direction forced up
                cnt_r      <= pend_val_r;
                dir_down_r <= 1'b0;
            end else if (timer_tick) begin
                moved_r <= 1'b1;
                if (!phase_mode) begin
                    // single slope: clear on period match
                    dir_down_r <= 1'b0;
                    if (cnt_r >= period_r) begin
                        cnt_r <= 10'h000;
                    end else begin
                        cnt_r <= cnt_r + 10'h001;
                    end
                end else if (!dir_down_r) begin
                    // dual slope rising: turn round at period
                    if (cnt_r >= period_r) begin
                        dir_down_r <= 1'b1;
                        cnt_r      <= cnt_r - 10'h001;
                    end else begin
                        cnt_r <= cnt_r + 10'h001;
                    end
                end else begin
                    // dual slope falling: turn round at bottom
                    if (cnt_r <= 10'h001) begin
                        cnt_r      <= 10'h000;
                        dir_down_r <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 10'h001;
                    end
                end
            end
        end
    end

    // shared staging byte: cpu writes, low-byte reads latch high bits
    always_ff @(posedge clk) begin
        if (rst) begin
            hs_r <= 3'h0;
        end else if (cpu_wr && cpu_addr == ADDR_HIGH) begin
            hs_r <= cpu_wdata[2:0];
        end else if (cpu_rd) begin
            // read low first, then high holds the rest
            unique case (cpu_addr)
                ADDR_CNT_LO: hs_r <= {1'b0, cnt_r[9:8]};
                ADDR_CMP_A:  hs_r <= cmp_r[0][10:8];
                ADDR_CMP_B:  hs_r <= cmp_r[1][10:8];
                ADDR_CMP_D:  hs_r <= cmp_r[2][10:8];
                ADDR_PERIOD: hs_r <= {1'b0, period_r[9:8]};
                default:     hs_r <= hs_r;
            endcase
        end
    end

    // period write with floor of three
    assign period_wr = {hs_r[1:0], cpu_wdata};

    // period, dead time and override registers
    always_ff @(posedge clk) begin
        if (rst) begin
            period_r <= PERIOD_RST;
            dead_r   <= DEAD_RST;
            ovr_r    <= 6'h00;
        end else if (cpu_wr) begin
            if (cpu_addr == ADDR_PERIOD) begin
                period_r <= (period_wr < PERIOD_MIN) ? PERIOD_MIN : period_wr;
            end
            if (cpu_addr == ADDR_DEAD) begin
                dead_r <= cpu_wdata;
            end
            if (cpu_addr == ADDR_OVERRIDE) begin
                ovr_r <= cpu_wdata[5:0];
            end
        end
    end

    // interrupt enable bits at their byte positions
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_r <= '0;
        end else if (cpu_wr && cpu_addr == ADDR_MASK) begin
            for (int i = 0; i < NUM_EVT; i++) begin
                mask_r[i] <= cpu_wdata[FLG_POS[i]];
            end
        end
    end

    // per channel compare, match, waveform and dead time
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [3:0] cmp_addr;
            logic [9:0] cmp_eff;
            assign cmp_addr = (ch == 0) ? ADDR_CMP_A : (ch == 1) ? ADDR_CMP_B : ADDR_CMP_D;
            // enhanced mode compares the upper ten of eleven bits
            assign cmp_eff  = enhanced_mode ? cmp_r[ch][10:1] : cmp_r[ch][9:0];
            // only a counting step can produce a match
            assign match[ch] = moved_r && (cnt_r == cmp_eff);

            // compare value, both parts transferred on low write
            always_ff @(posedge clk) begin
                if (rst) begin
                    cmp_r[ch] <= CMP_RST;
                end else if (cpu_wr && cpu_addr == cmp_addr) begin
                    cmp_r[ch] <= {hs_r, cpu_wdata};
                end
            end

            // sync stage between match and flag
            always_ff @(posedge clk) begin
                if (rst) begin
                    match_d_r[ch] <= 1'b0;
                end else begin
                    match_d_r[ch] <= match[ch];
                end
            end
            assign set_evt[ch] = match_d_r[ch];

            // waveform: set at bottom, cleared on match; dual slope by direction
            always_ff @(posedge clk) begin
                if (rst) begin
                    wave_r[ch] <= 1'b0;
                end else if (match[ch]) begin
                    wave_r[ch] <= phase_mode ? dir_down_r : 1'b0;
                end else if (!phase_mode && moved_r && cnt_r == 10'h000) begin
                    wave_r[ch] <= 1'b1;
                end
            end

            hsptr_deadtime u_dt (
                .clk       (clk),
                .rst       (rst),
                .tick      (timer_tick),
                .wave_in   (wave_r[ch]),
                .dt_true   (dead_r[DT_TRUE_LSB +: 4]),
                .dt_compl  (dead_r[DT_COMPL_LSB +: 4]),
                .true_out  (pair_w[2*ch]),
                .compl_out (pair_w[2*ch+1])
            );
        end
    endgenerate
    assign set_evt[EVT_OVF] = wrap_now;

    // flags: hardware set wins over vector and written-one clears
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r     <= '0;
            clr_pend_r <= '0;
        end else begin
            for (int i = 0; i < NUM_EVT; i++) begin
                clr_pend_r[i] <= cpu_wr && cpu_addr == ADDR_FLAGS && cpu_wdata[FLG_POS[i]];
                if (set_evt[i]) begin
                    flag_r[i] <= 1'b1;
                end else if (clr_pend_r[i] || vec_done[i]) begin
                    flag_r[i] <= 1'b0;
                end
            end
        end
    end

    // interrupt requests
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_req <= '0;
        end else begin
            irq_req <= flag_r & mask_r & {NUM_EVT{cpu_status_word_ibit}};
        end
    end

    // pin drive: in six-channel mode override bits select waveform or port value
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out <= 6'h00;
        end else begin
            for (int k = 0; k < 6; k++) begin
                if (six_mode) begin
                    pin_out[k] <= ovr_r[k] ? pair_w[k] : port_value[k];
                end else begin
                    pin_out[k] <= pair_w[k];
                end
            end
        end
    end

    // readback bytes for mask and flags
    always_comb begin
        mask_byte = 8'h00;
        flag_byte = 8'h00;
        for (int i = 0; i < NUM_EVT; i++) begin
            mask_byte[FLG_POS[i]] = mask_r[i];
            flag_byte[FLG_POS[i]] = flag_r[i];
        end
    end

    // registered read data
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            unique case (cpu_addr)
                ADDR_CNT_LO:   cpu_rdata <= cnt_r[7:0];
                ADDR_HIGH:     cpu_rdata <= {5'h00, hs_r};
                ADDR_CMP_A:    cpu_rdata <= cmp_r[0][7:0];
                ADDR_CMP_B:    cpu_rdata <= cmp_r[1][7:0];
                ADDR_PERIOD:   cpu_rdata <= period_r[7:0];
                ADDR_CMP_D:    cpu_rdata <= cmp_r[2][7:0];
                ADDR_MASK:     cpu_rdata <= mask_byte;
                ADDR_FLAGS:    cpu_rdata <= flag_byte;
                ADDR_DEAD:     cpu_rdata <= dead_r;
                ADDR_OVERRIDE: cpu_rdata <= {2'h0, ovr_r};
                default:       cpu_rdata <= 8'h00;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cnt_wr_sync;
        cpu_wr && cpu_addr == ADDR_CNT_LO && !async_clocking;
    endsequence
    sequence s_quiet;
        !(cpu_wr && cpu_addr == ADDR_CNT_LO);
    endsequence

    AST_OVR_PIN: assert property (
        six_mode && ovr_r[0] |=> pin_out[0] == $past(pair_w[0]))
        else $error("override pin not following waveform");
    AST_CNT_WR_LAND: assert property (
        s_cnt_wr_sync ##1 s_quiet |-> ##2 cnt_r == $past(pend_val_r) && !dir_down_r)
        else $error("counter write did not land two cycles later");
    AST_WR_UP: assert property (
        land |=> !dir_down_r)
        else $error("counter not counting up after write");
    AST_HIGH_RSVD: assert property (
        cpu_rd && cpu_addr == ADDR_HIGH |=> (cpu_rdata & HS_RSVD_MASK) == 8'h00)
        else $error("reserved staging bits read nonzero");
    AST_NO_SW_MATCH: assert property (
        land |=> match == '0)
        else $error("software write caused compare match");
    AST_FLAG_DELAY: assert property (
        match[0] |-> ##2 flag_r[0])
        else $error("compare flag a not set after sync delay");
    AST_PERIOD_CLR: assert property (
        timer_tick && !land && !phase_mode && cnt_r >= period_r |=> cnt_r == 10'h000)
        else $error("counter not cleared at period");
    AST_PERIOD_MIN: assert property (
        cpu_wr && cpu_addr == ADDR_PERIOD && period_wr < PERIOD_MIN |=> period_r == PERIOD_MIN)
        else $error("period below three not floored");
    AST_IRQ: assert property (
        ##1 irq_req[0] == $past(flag_r[0] && mask_r[0] && cpu_status_word_ibit))
        else $error("compare a request mismatch");
    AST_OVF_IRQ: assert property (
        !$past(cpu_status_word_ibit) |-> !irq_req[EVT_OVF])
        else $error("overflow request without global bit");
    AST_CLR: assert property (
        vec_done[0] && !set_evt[0] |=> !flag_r[0])
        else $error("flag a not cleared by vector");
    AST_OVF_WRAP: assert property (
        wrap_now && !phase_mode |=> flag_r[EVT_OVF] && cnt_r == 10'h000)
        else $error("overflow flag not with wrap");
endmodule

//--- testbench/hsptr_pin_load.sv
`timescale 1ns/10ps
// gate driver load on the six compare pins
module hsptr_pin_load (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [5:0] pins,
    output int              overlap_cnt
);
    // counts cycles with both legs of one pair driven high
    always_ff @(posedge clk) begin
        if (rst) begin
            overlap_cnt <= 0;
        end else if ((pins[0] & pins[1]) | (pins[2] & pins[3]) | (pins[4] & pins[5])) begin
            overlap_cnt <= overlap_cnt + 1;
        end
    end
endmodule

//--- testbench/high_speed_pwm_timer_regs_tb.sv
`timescale 1ns/10ps
module high_speed_pwm_timer_regs_tb;
    import hsptr_pkg::*;
    logic       clk, rst, cpu_wr, cpu_rd, ibit, tick_r, pwm_en, enh, async_r;
    logic [3:0] cpu_addr, vec_done, irq_req;
    logic [7:0] cpu_wdata, cpu_rdata;
    logic [1:0] wgm;
    logic [5:0] port_value, pin_out;
    int         overlap_cnt;
    int         err_total, n_compared, cycles; // score and watchdog

    hsptr_top uut (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_status_word_ibit(ibit), .vec_done(vec_done), .timer_tick(tick_r),
        .pwm_enable(pwm_en), .wgm_mode(wgm), .enhanced_mode(enh),
        .async_clocking(async_r), .port_value(port_value), .pin_out(pin_out),
        .irq_req(irq_req));
    hsptr_pin_load load (.clk(clk), .rst(rst), .pins(pin_out), .overlap_cnt(overlap_cnt));

    // compare and report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one write strobe, taken at the second edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge clk);
        cpu_wr    <= 1'b0;
    endtask
    // read, then compare the answer one cycle later
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge clk);
        cpu_rd   <= 1'b0;
        @(negedge clk);
        chk(cpu_rdata, exp);
    endtask
    // prescaled timer steps, idle cycle first so a landing write is not hit
    task automatic tick(input int n);
        @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            tick_r <= 1'b1;
            @(posedge clk);
            tick_r <= 1'b0;
        end
        // trailing cycle lets the delayed compare flags settle
        @(posedge clk);
    endtask
    // settle a few cycles, then look at registered outputs mid-cycle
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic done(input string name);
        $display("test %s done", name);
    endtask
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        {rst, cpu_wr, cpu_rd, ibit, tick_r, pwm_en, enh, async_r} = 8'h80;
        {cpu_addr, vec_done, cpu_wdata, wgm, port_value} = '0;
        {err_total, n_compared, cycles} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // reset values, staging byte fields
        rc(ADDR_PERIOD, 8'hff);
        rc(ADDR_HIGH, 8'h03);
        rc(ADDR_DEAD, DEAD_RST);
        rc(4'hf, 8'h00);
        wr(ADDR_HIGH, 8'hff);
        rc(ADDR_HIGH, 8'h07);
        wr(ADDR_HIGH, 8'h04);
        wr(ADDR_CMP_B, 8'h10);
        wr(ADDR_HIGH, 8'h00);
        rc(ADDR_CMP_B, 8'h10);
        rc(ADDR_HIGH, 8'h04);
        wr(ADDR_DEAD, 8'h5a);
        rc(ADDR_DEAD, 8'h5a);
        done("registers");
        // counter write landing, sync then async
        wr(ADDR_HIGH, 8'h00);
        wr(ADDR_CNT_LO, 8'h34);
        rc(ADDR_CNT_LO, 8'h00);
        rc(ADDR_CNT_LO, 8'h34);
        wr(ADDR_HIGH, 8'h02);
        wr(ADDR_CNT_LO, 8'h9c);
        wr(ADDR_HIGH, 8'h00);
        rc(ADDR_CNT_LO, 8'h9c);
        rc(ADDR_HIGH, 8'h02);
        @(posedge clk);
        async_r <= 1'b1;
        wr(ADDR_CNT_LO, 8'h56);
        rc(ADDR_CNT_LO, 8'h56);
        @(posedge clk);
        async_r <= 1'b0;
        done("counter");
        // dual slope: turnaround, restart upward, overflow at zero
        @(posedge clk);
        pwm_en <= 1'b1;
        wgm    <= 2'b01;
        wr(ADDR_HIGH, 8'h00);
        wr(ADDR_PERIOD, 8'h05);
        wr(ADDR_CNT_LO, 8'h00);
        tick(7);
        rc(ADDR_CNT_LO, 8'h03);
        wr(ADDR_CNT_LO, 8'h02);
        tick(1);
        rc(ADDR_CNT_LO, 8'h03);
        wr(ADDR_PERIOD, 8'h01);
        rc(ADDR_PERIOD, 8'h03);
        wr(ADDR_FLAGS, 8'hff);
        wr(ADDR_CNT_LO, 8'h00);
        rc(ADDR_FLAGS, 8'h00);
        tick(5);
        rc(ADDR_FLAGS, 8'h00);
        tick(1);
        rc(ADDR_FLAGS, 8'hc4);
        done("dual slope");
        // normal mode: period clears counter, overflow on wrap
        @(posedge clk);
        pwm_en <= 1'b0;
        wr(ADDR_FLAGS, 8'hff);
        tick(3);
        rc(ADDR_FLAGS, 8'h00);
        tick(1);
        rc(ADDR_FLAGS, 8'hc4);
        rc(ADDR_CNT_LO, 8'h00);
        done("normal");
        // interrupt requests, vector and written-one clears
        wr(ADDR_MASK, 8'h04);
        settle();
        chk({4'h0, irq_req}, 8'h00);
        @(posedge clk);
        ibit <= 1'b1;
        settle();
        chk({4'h0, irq_req}, 8'h08);
        wr(ADDR_MASK, 8'h44);
        settle();
        chk({4'h0, irq_req}, 8'h09);
        @(posedge clk);
        vec_done <= 4'h1;
        @(posedge clk);
        vec_done <= 4'h0;
        rc(ADDR_FLAGS, 8'h84);
        settle();
        chk({4'h0, irq_req}, 8'h08);
        wr(ADDR_FLAGS, 8'h04);
        // written-one clear lands a cycle after the strobe
        @(posedge clk);
        rc(ADDR_FLAGS, 8'h80);
        settle();
        chk({4'h0, irq_req}, 8'h00);
        done("interrupts");
        // six-channel pin override and dead-time pairs
        @(posedge clk);
        pwm_en     <= 1'b1;
        wgm        <= 2'b10;
        port_value <= 6'h15;
        wr(ADDR_DEAD, 8'h11);
        wr(ADDR_OVERRIDE, 8'h00);
        settle();
        chk({2'h0, pin_out}, 8'h15);
        wr(ADDR_OVERRIDE, 8'h01);
        settle();
        chk({3'h0, pin_out[5:1]}, 8'h0a);
        chk({7'h00, pin_out[0]}, 8'h00);
        wr(ADDR_CMP_A, 8'h02);
        wr(ADDR_OVERRIDE, 8'h3f);
        tick(24);
        chk(8'(overlap_cnt), 8'h00);
        done("pins");
        // enhanced compare: upper ten of eleven bits
        @(posedge clk);
        pwm_en <= 1'b0;
        enh    <= 1'b1;
        wr(ADDR_HIGH, 8'h00);
        wr(ADDR_CMP_A, 8'h04);
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_FLAGS, 8'hff);
        tick(2);
        rc(ADDR_FLAGS, 8'h40);
        done("enhanced");
        print_verdict();
    end
endmodule
